// ### xwm_pkg.sv
/*
 * Package for the external watchdog monitor: register offsets, field
 * positions, reset values and shared types.
 * Assumes a 32-bit APB bus and a 100 MHz system clock.
 */
package xwm_pkg;
    localparam logic [7:0] XWM_OFS_CTRL = 8'h00;
    localparam logic [7:0] XWM_OFS_CLKSEL = 8'h04;
    localparam logic [7:0] XWM_OFS_DIV = 8'h08;
    localparam logic [7:0] XWM_OFS_CMPL = 8'h0C;
    localparam logic [7:0] XWM_OFS_CMPH = 8'h10;
    localparam logic [7:0] XWM_OFS_SERVICE = 8'h14;
    localparam logic [7:0] XWM_OFS_STATUS = 8'h18;
    localparam logic [7:0] XWM_OFS_MASK = 8'h1C;
    localparam logic [7:0] XWM_OFS_COUNT = 8'h20;

    localparam int XWM_CTRL_EN = 0;
    localparam int XWM_CTRL_IN_EN = 1;
    localparam int XWM_CTRL_POL = 2;
    localparam int XWM_CTRL_IRQ_EN = 3;

    localparam int XWM_ST_EXPIRE = 0;
    localparam int XWM_ST_BADREF = 1;
    localparam int XWM_ST_INPUT = 2;
    localparam int XWM_NUM_EVT = 3;

    localparam logic [7:0] XWM_CMPL_RST = 8'h00;
    localparam logic [7:0] XWM_CMPH_RST = 8'hFE;
    localparam logic [7:0] XWM_DIV_RST = 8'h00;
    localparam logic [1:0] XWM_CLKSEL_RST = 2'h0;
    localparam logic [7:0] XWM_SERVICE_KEY1 = 8'hB4;
    localparam logic [7:0] XWM_SERVICE_KEY2 = 8'h2C;
    localparam int XWM_NUM_CFG = 5;

    typedef struct packed {
        logic enable;
        logic input_enable;
        logic input_active_high;
        logic interrupt_enable_bit;
        logic [1:0] clock_source;
        logic [7:0] counter_clock_divider;
        logic [7:0] compare_low_value;
        logic [7:0] compare_high_value;
    } xwm_cfg_s;

    typedef enum logic [2:0] {
        XWM_SVC_IDLE = 3'b001,
        XWM_SVC_KEY1 = 3'b010,
        XWM_SVC_DONE = 3'b100
    } xwm_svc_e;
endpackage

// ### xwm_top.sv
/*
 * External watchdog monitor with APB register access.
 * Assumes: monitor input and clock source ticks synchronous to clk_sys;
 * the APB master keeps the standard two-phase protocol.
 */
// The APB slave port and the placing of the registers were decided locally.
// Function
// RQ1: each control bit and config register accepts one write after reset, except irq enable.
// RQ2: a repeated write to a write-once item returns pslverr.
// RQ3: interrupt enable bit may be changed freely without error.
// RQ4: monitor runs immediately once enable and configuration are written.
// RQ5: service sequence clears the watchdog counter to zero.
// RQ6: counter ticks at selected source rate divided by divider plus one.
// RQ7: software keeps compare high value at or below 0xFE.
// RQ8: monitor input asserts low or high per polarity selection.
// RQ9: refresh only inside compare window; faults assert output and interrupt.
`timescale 1ns/1ps
module xwm_top
    import xwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] lpo_tick,
    input wire logic monitor_in,
    output logic wdog_out,
    output logic irq
);
    xwm_cfg_s cfg_ff;
    logic [XWM_NUM_CFG-1:0] written_ff;
    logic [7:0] count_ff;
    logic [7:0] prediv_ff;
    logic [XWM_NUM_EVT-1:0] status_ff;
    logic [XWM_NUM_EVT-1:0] mask_ff;
    logic wdog_out_ff;
    logic [31:0] prdata_ff;
    xwm_svc_e svc_ff;
    xwm_svc_e nxt_svc;

    logic acc;
    logic wr;
    logic rd;
    logic ctrl_wr;
    logic once_err;
    logic unmapped;
    logic tick;
    logic in_asserted;
    logic in_window;
    logic refresh;
    logic [XWM_NUM_EVT-1:0] evt;
    logic [4:0] idx;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign idx = paddr[6:2];
    assign unmapped = (paddr > XWM_OFS_COUNT) || (paddr[1:0] != 2'h0);

    // map a config offset to its write-once slot
    always_comb begin
        once_err = 1'b0;
        ctrl_wr = 1'b0;
        unique case (paddr)
            XWM_OFS_CTRL: begin
                ctrl_wr = 1'b1;
                once_err = written_ff[0]; // [RQ2]
            end
            XWM_OFS_CLKSEL: once_err = written_ff[1]; // [RQ2]
            XWM_OFS_DIV: once_err = written_ff[2]; // [RQ2]
            XWM_OFS_CMPL: once_err = written_ff[3]; // [RQ2]
            XWM_OFS_CMPH: once_err = written_ff[4]; // [RQ2]
            default: once_err = 1'b0;
        endcase
    end

    // zero-wait slave; a second control write that only touches the
    // interrupt enable bit with other bits unchanged is still accepted
    logic ctrl_irq_only;
    assign ctrl_irq_only = ctrl_wr && written_ff[0]
        && pwdata[XWM_CTRL_EN] == cfg_ff.enable
        && pwdata[XWM_CTRL_IN_EN] == cfg_ff.input_enable
        && pwdata[XWM_CTRL_POL] == cfg_ff.input_active_high; // [RQ3]

    logic wr_err;
    assign wr_err = wr && once_err && !ctrl_irq_only;
    assign pready = 1'b1;
    assign pslverr = acc && (unmapped || wr_err);
    assign prdata = prdata_ff;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_ff.enable <= 1'b0;
            cfg_ff.input_enable <= 1'b0;
            cfg_ff.input_active_high <= 1'b0;
            cfg_ff.interrupt_enable_bit <= 1'b0;
            cfg_ff.clock_source <= XWM_CLKSEL_RST;
            cfg_ff.counter_clock_divider <= XWM_DIV_RST;
            cfg_ff.compare_low_value <= XWM_CMPL_RST;
            cfg_ff.compare_high_value <= XWM_CMPH_RST;
            written_ff <= '0;
        end else if (wr && !unmapped && !wr_err) begin
            // a refused write stores nothing, not even the irq enable bit
            if (ctrl_wr) begin
                cfg_ff.interrupt_enable_bit <= pwdata[XWM_CTRL_IRQ_EN]; // [RQ3]
                if (!written_ff[0]) begin
                    cfg_ff.enable <= pwdata[XWM_CTRL_EN]; // [RQ1]
                    cfg_ff.input_enable <= pwdata[XWM_CTRL_IN_EN];
                    cfg_ff.input_active_high <= pwdata[XWM_CTRL_POL];
                    written_ff[0] <= 1'b1;
                end
            end else if (!once_err) begin
                unique case (paddr)
                    XWM_OFS_CLKSEL: begin
                        cfg_ff.clock_source <= pwdata[1:0]; // [RQ1]
                        written_ff[1] <= 1'b1;
                    end
                    XWM_OFS_DIV: begin
                        cfg_ff.counter_clock_divider <= pwdata[7:0]; // [RQ1]
                        written_ff[2] <= 1'b1;
                    end
                    XWM_OFS_CMPL: begin
                        cfg_ff.compare_low_value <= pwdata[7:0]; // [RQ1]
                        written_ff[3] <= 1'b1;
                    end
                    XWM_OFS_CMPH: begin
                        cfg_ff.compare_high_value <= pwdata[7:0]; // [RQ1]
                        written_ff[4] <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // service is a two-write key sequence so a stray write cannot refresh
    always_comb begin
        nxt_svc = svc_ff;
        unique case (svc_ff)
            XWM_SVC_IDLE, XWM_SVC_DONE: begin
                nxt_svc = XWM_SVC_IDLE;
                if (wr && paddr == XWM_OFS_SERVICE
                    && pwdata[7:0] == XWM_SERVICE_KEY1)
                    nxt_svc = XWM_SVC_KEY1;
            end
            XWM_SVC_KEY1: begin
                if (wr && paddr == XWM_OFS_SERVICE)
                    nxt_svc = (pwdata[7:0] == XWM_SERVICE_KEY2)
                        ? XWM_SVC_DONE : XWM_SVC_IDLE;
            end
            default: nxt_svc = XWM_SVC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            svc_ff <= XWM_SVC_IDLE;
        else
            svc_ff <= nxt_svc;
    end

    assign refresh = (svc_ff == XWM_SVC_DONE);
    assign in_window = (count_ff >= cfg_ff.compare_low_value)
        && (count_ff <= cfg_ff.compare_high_value); // [RQ9]
    assign in_asserted = cfg_ff.input_active_high ? monitor_in
        : !monitor_in; // [RQ8]
    assign tick = lpo_tick[cfg_ff.clock_source]
        && (prediv_ff == cfg_ff.counter_clock_divider); // [RQ6]

    // divider and counter run as soon as the enable bit is in
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prediv_ff <= 8'h00;
            count_ff <= 8'h00;
        end else if (!cfg_ff.enable) begin
            prediv_ff <= 8'h00;
            count_ff <= 8'h00;
        end else begin
            if (lpo_tick[cfg_ff.clock_source])
                prediv_ff <= tick ? 8'h00 : prediv_ff + 8'h01; // [RQ6] [RQ4]
            if (refresh && in_window)
                count_ff <= 8'h00; // [RQ5]
            else if (tick && count_ff <= cfg_ff.compare_high_value)
                count_ff <= count_ff + 8'h01;
        end
    end

    // expiry once the count passes the high compare value
    assign evt[XWM_ST_EXPIRE] = cfg_ff.enable
        && count_ff > cfg_ff.compare_high_value; // [RQ9]
    assign evt[XWM_ST_BADREF] = cfg_ff.enable && refresh && !in_window;
    assign evt[XWM_ST_INPUT] = cfg_ff.enable && cfg_ff.input_enable
        && in_asserted;

    genvar g;
    generate
        for (g = 0; g < XWM_NUM_EVT; g++) begin : g_evt
            // set wins over a simultaneous write-one clear
            always_ff @(posedge clk_sys) begin
                if (!reset_n)
                    status_ff[g] <= 1'b0;
                else if (evt[g])
                    status_ff[g] <= 1'b1;
                else if (wr && paddr == XWM_OFS_STATUS && pwdata[g])
                    status_ff[g] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            mask_ff <= '0;
        else if (wr && paddr == XWM_OFS_MASK)
            mask_ff <= pwdata[XWM_NUM_EVT-1:0];
    end

    // output stays asserted until the next processor reset
    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            wdog_out_ff <= 1'b0;
        else if (|evt)
            wdog_out_ff <= 1'b1; // [RQ9]
    end
    assign wdog_out = wdog_out_ff;
    assign irq = cfg_ff.interrupt_enable_bit
        && |(status_ff & mask_ff); // [RQ9]

    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                XWM_OFS_CTRL: prdata_ff <= {28'h0,
                    cfg_ff.interrupt_enable_bit, cfg_ff.input_active_high,
                    cfg_ff.input_enable, cfg_ff.enable};
                XWM_OFS_CLKSEL: prdata_ff <= {30'h0, cfg_ff.clock_source};
                XWM_OFS_DIV: prdata_ff <= {24'h0,
                    cfg_ff.counter_clock_divider};
                XWM_OFS_CMPL: prdata_ff <= {24'h0, cfg_ff.compare_low_value};
                XWM_OFS_CMPH: prdata_ff <= {24'h0, cfg_ff.compare_high_value};
                XWM_OFS_STATUS: prdata_ff <= {29'h0, status_ff};
                XWM_OFS_MASK: prdata_ff <= {29'h0, mask_ff};
                XWM_OFS_COUNT: prdata_ff <= {24'h0, count_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end
    logic unused_idx;
    assign unused_idx = ^idx || rd;
endmodule

// ### xwm_top_properties.sv
/*
 * Checker for the watchdog monitor top: bus refusals and fault outputs.
 * Assumes it is bound to xwm_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module xwm_checker
    import xwm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic monitor_in,
    input wire logic wdog_out,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic wr;
    logic [7:0] done_ff;
    logic [2:0] ctl_ff;
    assign wr = psel && penable && pwrite;
    // a slot counts as used by its first write, even a refused one
    always_ff @(posedge clk_sys) begin
        if (!reset_n) done_ff <= 8'h00;
        else if (wr && paddr[1:0] == 2'h0 && paddr <= XWM_OFS_CMPH)
            done_ff[paddr[4:2]] <= 1'b1;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) ctl_ff <= 3'h0;
        else if (wr && paddr == XWM_OFS_CTRL && !done_ff[0])
            ctl_ff <= pwdata[2:0];
    end
    sequence s_ctl_again;
        wr && paddr == XWM_OFS_CTRL && done_ff[0];
    endsequence
    sequence s_in_active;
        done_ff[0] && ctl_ff[1:0] == 2'h3 && monitor_in == ctl_ff[2];
    endsequence
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("error flag outside access");
    a_cfg_once: assert property (wr && paddr != XWM_OFS_CTRL
        && paddr <= XWM_OFS_CMPH && paddr[1:0] == 2'h0
        && done_ff[paddr[4:2]] |-> pslverr) else $error("rewrite accepted");
    a_ctrl_change: assert property (s_ctl_again
        and pwdata[2:0] != ctl_ff |-> pslverr) else $error("ctrl rewrite");
    a_irqen_free: assert property (s_ctl_again
        and pwdata[2:0] == ctl_ff |-> !pslverr) else $error("irq bit refused");
    a_service_ok: assert property (wr && paddr == XWM_OFS_SERVICE
        |-> !pslverr) else $error("service refused");
    a_input_trip: assert property (s_in_active |-> ##[1:3] wdog_out)
        else $error("input fault missed");
    a_wdog_sticky: assert property (wdog_out |=> wdog_out)
        else $error("fault output dropped");
    a_irq_cause: assert property (irq |-> ##[0:1] wdog_out)
        else $error("irq without fault");
endmodule
bind xwm_top xwm_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .monitor_in(monitor_in),
    .wdog_out(wdog_out), .irq(irq));

// ### xwm_far_end.sv
/*
 * External circuit model driving the monitor input pin.
 * Assumes the bench changes trip and polarity just after clock edges.
 */
`timescale 1ns/1ps
module xwm_far_end (
    input wire logic trip,
    input wire logic active_high,
    output logic monitor_in
);
    // idle level is the inverse of the asserted level
    assign monitor_in = trip ~^ active_high;
endmodule

// ### external_watchdog_monitor_tb.sv
/*
 * Self-checking bench for the watchdog monitor over APB.
 * Assumes zero-wait APB and keyed service writes as in the package.
 */
`timescale 1ns/1ps
module external_watchdog_monitor_tb;
    import xwm_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trip = 1'b0;
    logic pol = 1'b0, pready, pslverr, monitor_in, wdog_out, irq, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] lpo_tick = 4'h0;
    int failures = 0, checks = 0, cyc = 0;
    xwm_top u_xwm_top (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lpo_tick(lpo_tick), .monitor_in(monitor_in),
        .wdog_out(wdog_out), .irq(irq));
    xwm_far_end u_xwm_far_end (.trip(trip), .active_high(pol),
        .monitor_in(monitor_in));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic tally_and_finish();
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk("pslverr", {31'h0, err}, {31'h0, e});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", rd, e);
    endtask
    task automatic rst();
        reset_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic service();
        wr(XWM_OFS_SERVICE, {24'h0, XWM_SERVICE_KEY1}, 1'b0);
        wr(XWM_OFS_SERVICE, {24'h0, XWM_SERVICE_KEY2}, 1'b0);
    endtask
    initial begin
        int sel, div, pulses;
        logic [3:0] t;
        pulses = $urandom(32'hA26A486D);
        pulses = 0;
        rst();
        rdc(XWM_OFS_CMPH, {24'h0, XWM_CMPH_RST});
        sel = $urandom_range(3, 0);
        div = $urandom_range(2, 0);
        wr(XWM_OFS_CLKSEL, 32'(sel), 1'b0);
        wr(XWM_OFS_DIV, 32'(div), 1'b0);
        wr(XWM_OFS_CMPL, 32'h1, 1'b0);
        wr(XWM_OFS_CMPH, 32'h40, 1'b0);
        wr(XWM_OFS_MASK, 32'h0, 1'b0);
        wr(XWM_OFS_CTRL, 32'h9, 1'b0);
        wr(XWM_OFS_DIV, 32'h7, 1'b1);
        rdc(XWM_OFS_DIV, 32'(div));
        wr(XWM_OFS_CTRL, 32'h1, 1'b0);
        wr(XWM_OFS_CTRL, 32'h9, 1'b0);
        wr(XWM_OFS_CTRL, 32'hB, 1'b1);
        wr(XWM_OFS_CTRL, 32'h3, 1'b1);
        rdc(XWM_OFS_CTRL, 32'h9);
        wr(8'h24, 32'h0, 1'b1);
        repeat (24) begin
            t = 4'($urandom);
            lpo_tick <= t;
            if (t[sel]) pulses++;
            @(posedge clk_sys);
        end
        lpo_tick <= 4'h0;
        rdc(XWM_OFS_COUNT, 32'(pulses / (div + 1)));
        service();
        rdc(XWM_OFS_COUNT, 32'h0);
        rdc(XWM_OFS_STATUS, 32'h0);
        service();
        rdc(XWM_OFS_STATUS, 32'h2);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(XWM_OFS_MASK, 32'h7, 1'b0);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(XWM_OFS_STATUS, 32'h2, 1'b0);
        chk("irq", {31'h0, irq}, 32'h0);
        chk("wdog_out", {31'h0, wdog_out}, 32'h1);
        for (int p = 0; p < 2; p++) begin
            rst();
            pol <= p[0];
            wr(XWM_OFS_CTRL, {29'h0, p[0], 2'h3}, 1'b0);
            repeat (4) @(posedge clk_sys);
            chk("wdog_out", {31'h0, wdog_out}, 32'h0);
            trip <= 1'b1;
            repeat (4) @(posedge clk_sys);
            chk("wdog_out", {31'h0, wdog_out}, 32'h1);
            rdc(XWM_OFS_STATUS, 32'h4);
            trip <= 1'b0;
        end
        // expiry: high compare 2, divider 0, source 0, three ticks pass it
        rst();
        wr(XWM_OFS_CMPH, 32'h2, 1'b0);
        wr(XWM_OFS_CTRL, 32'h1, 1'b0);
        lpo_tick <= 4'h1;
        repeat (4) @(posedge clk_sys);
        lpo_tick <= 4'h0;
        rdc(XWM_OFS_COUNT, 32'h3);
        rdc(XWM_OFS_STATUS, 32'h1);
        chk("wdog_out", {31'h0, wdog_out}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule
